/* File: rtl/arsc_pkg.sv */
// Constants for the converter reference and ground selection control
// Contract
// - Source field steers the converter reference
// - High-speed reference powered only when converter needs
// - Bit 0 powers precision reference onto pin
// - Bit 5 picks normal or analog ground pin
// - Sensor sampling always uses internal ground
// - High-speed reference conversion uses internal ground
// - Bit 2 enables sensor, else output floats
// - Bits 7:6 and 1 read zero
// - Register sits on page 0x0, address 0xD1
package arsc_pkg;
    localparam logic [7:0] ARSC_SFR_ADDR = 8'hD1;
    localparam logic [3:0] ARSC_SFR_PAGE = 4'h0;
    localparam int ARSC_PREC_EN_BIT = 0;
    localparam int ARSC_SENS_EN_BIT = 2;
    localparam int ARSC_SRC_LSB = 3;
    localparam int ARSC_GND_SEL_BIT = 5;
    localparam logic [7:0] ARSC_WRITE_MASK = 8'h3D;
    localparam logic [7:0] ARSC_RESET_VAL = 8'h18;

    typedef enum logic [1:0] {
        ARSC_SRC_EXT_PIN = 2'h0,
        ARSC_SRC_MAIN_SUPPLY = 2'h1,
        ARSC_SRC_DIG_SUPPLY = 2'h2,
        ARSC_SRC_HS_REF = 2'h3
    } arsc_src_t;

    typedef enum logic [1:0] {
        ARSC_GND_NORMAL_PIN = 2'h0,
        ARSC_GND_ANALOG_PIN = 2'h1,
        ARSC_GND_INTERNAL = 2'h2
    } arsc_gnd_t;
endpackage

/* File: rtl/arsc_ctrl.sv */
// Register and override logic for converter reference and ground selection
`timescale 1ns/1ps
module arsc_ctrl
    import arsc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // Special function register port
    input wire logic [3:0] i_sfr_page,
    input wire logic [7:0] i_sfr_addr,
    input wire logic i_sfr_wr,
    input wire logic i_sfr_rd,
    input wire logic [7:0] i_sfr_wdata,
    output logic [7:0] o_sfr_rdata,
    // Converter phase status
    input wire logic i_conv_active,
    input wire logic i_conv_phase,
    input wire logic i_track_sensor,
    // Analog controls
    output arsc_src_t o_reference_source_select,
    output logic o_hs_ref_power,
    output logic o_precision_reference_enable,
    output logic o_ext_pin_connect,
    output arsc_gnd_t o_ground_route,
    output logic o_thermal_sensor_enable
);

    ////////////////////////////////////////////////////////////////////////
    // Registered state
    ////////////////////////////////////////////////////////////////////////

    // One flop per analog control so that every output leaves a register
    typedef struct packed {
        // Software-visible register and the held read data
        logic [7:0] reg_val;
        logic [7:0] rdata;

        // Analog controls
        arsc_src_t src;
        logic hs_pwr;
        logic prec_en;
        logic pin_conn;
        arsc_gnd_t gnd;
        logic sens_en;
    } arsc_state_t;

    arsc_state_t state_q;
    arsc_state_t state_d;

    // Access decode
    logic page_ok;
    logic addr_ok;
    logic hit;
    // Strobes qualified by the register decode
    logic wr_hit;
    logic rd_hit;
    logic rd_miss;

    // Register contents as they stand after this cycle's write
    logic [7:0] nreg;
    arsc_src_t nsrc;
    logic src_is_hs;
    logic prec_sel;
    logic sens_sel;
    logic gnd_pin_sel;

    // Converter phase conditions that override the ground choice
    logic sensor_sampling;
    logic hs_converting;

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    ////////////////////////////////////////////////////////////////////////

    // Source field position is fixed by the register map
    function automatic arsc_src_t source_field(input logic [7:0] value);
        return arsc_src_t'(value[ARSC_SRC_LSB +: 2]);
    endfunction

    // Only implemented bits are returned; unused bits always read zero
    function automatic logic [7:0] read_view(input logic [7:0] value);
        return value & ARSC_WRITE_MASK;
    endfunction

    // The high-speed reference draws power only while the converter needs
    // it; tracking and conversion both count as need
    function automatic logic hs_power(input logic hs_selected, input logic demand);
        return hs_selected && demand;
    endfunction

    // Ground route priority: sensor sampling, then high-speed reference
    // conversion, then the software choice between the two pins
    function automatic arsc_gnd_t ground_route(
        input logic sampling_sensor,
        input logic converting_hs,
        input logic analog_pin_sel
    );
        arsc_gnd_t route;
        if (sampling_sensor) begin
            route = ARSC_GND_INTERNAL;
        end else if (converting_hs) begin
            route = ARSC_GND_INTERNAL;
        end else if (analog_pin_sel) begin
            route = ARSC_GND_ANALOG_PIN;
        end else begin
            route = ARSC_GND_NORMAL_PIN;
        end
        return route;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Next state
    ////////////////////////////////////////////////////////////////////////

    // Controls are taken from the register as written this cycle, so a
    // write reaches the analog section one cycle later, like a read; the
    // overrides follow the converter phase with the same single cycle
    always_comb begin
        state_d = state_q;

        // Pages other than zero place other registers at this address
        page_ok = (i_sfr_page == ARSC_SFR_PAGE);
        addr_ok = (i_sfr_addr == ARSC_SFR_ADDR);
        hit = page_ok && addr_ok;
        wr_hit = i_sfr_wr && hit;
        rd_hit = i_sfr_rd && hit;
        rd_miss = i_sfr_rd && !hit;

        // Unused bits are dropped at the write so they never reach an
        // analog control or the read path
        nreg = state_q.reg_val;
        if (wr_hit) begin
            nreg = i_sfr_wdata & ARSC_WRITE_MASK;
        end
        state_d.reg_val = nreg;

        // Read data holds until the next read so the bus sees a stable value;
        // a read in the cycle of a write returns the old contents
        if (rd_hit) begin
            state_d.rdata = read_view(state_q.reg_val);
        end else if (rd_miss) begin
            // Other registers answer for themselves; this block gives zero
            state_d.rdata = 8'h00;
        end

        // Field extraction
        nsrc = source_field(nreg);
        src_is_hs = (nsrc == ARSC_SRC_HS_REF);
        prec_sel = nreg[ARSC_PREC_EN_BIT];
        sens_sel = nreg[ARSC_SENS_EN_BIT];
        gnd_pin_sel = nreg[ARSC_GND_SEL_BIT];

        // Reference source multiplexer
        state_d.src = nsrc;

        // No software action is needed to start or stop the high-speed
        // reference; a conversion from another source leaves it off
        state_d.hs_pwr = hs_power(src_is_hs, i_conv_active);

        // Power and pin connection move together, so the pin is never
        // loaded by an unpowered precision reference
        state_d.prec_en = prec_sel;
        state_d.pin_conn = prec_sel;

        // With the sensor off its output floats and conversions of it are
        // meaningless; nothing here stops software from converting it
        state_d.sens_en = sens_sel;

        // Ground overrides win over the software choice, whatever the
        // analog ground select bit holds
        sensor_sampling = i_track_sensor && !i_conv_phase;
        hs_converting = i_conv_phase && src_is_hs;
        state_d.gnd = ground_route(
            sensor_sampling,
            hs_converting,
            gnd_pin_sel
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    ////////////////////////////////////////////////////////////////////////

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            // Register and bus
            state_q.reg_val <= ARSC_RESET_VAL;
            state_q.rdata <= 8'h00;

            // Controls match the reset contents: high-speed source chosen,
            // but unpowered until the converter asks for it
            state_q.src <= arsc_src_t'(ARSC_RESET_VAL[ARSC_SRC_LSB +: 2]);
            state_q.hs_pwr <= 1'b0;
            state_q.prec_en <= ARSC_RESET_VAL[ARSC_PREC_EN_BIT];
            state_q.pin_conn <= ARSC_RESET_VAL[ARSC_PREC_EN_BIT];
            state_q.gnd <= ARSC_GND_NORMAL_PIN;
            state_q.sens_en <= ARSC_RESET_VAL[ARSC_SENS_EN_BIT];
        end else begin
            state_q <= state_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from the state flops
    ////////////////////////////////////////////////////////////////////////

    // Register bus
    assign o_sfr_rdata = state_q.rdata;

    // Reference selection and power
    assign o_reference_source_select = state_q.src;
    assign o_hs_ref_power = state_q.hs_pwr;
    // Enable and pin connection are one flop pair driven together
    assign o_precision_reference_enable = state_q.prec_en;
    assign o_ext_pin_connect = state_q.pin_conn;

    // Ground route and sensor power
    assign o_ground_route = state_q.gnd;
    assign o_thermal_sensor_enable = state_q.sens_en;

endmodule

/* File: dv/arsc_props.sv */
// Port assertions for the reference control
`timescale 1ns/1ps
module arsc_chk (input logic i_clk, i_nrst, i_sfr_wr, i_sfr_rd, i_conv_active,
    i_conv_phase, i_track_sensor, o_hs_ref_power, o_precision_reference_enable,
    o_thermal_sensor_enable, input logic [3:0] i_sfr_page,
    input logic [7:0] i_sfr_addr, i_sfr_wdata, o_sfr_rdata,
    input logic [1:0] o_reference_source_select, o_ground_route);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    wire w = i_sfr_wr && i_sfr_page == 4'h0 && i_sfr_addr == 8'hD1;
    wire h = o_reference_source_select == 2'h3;
    wire g = o_ground_route == 2'h2;
    a_src_wr: assert property (w |=> o_reference_source_select == $past(i_sfr_wdata[4:3]))
        else $error("src");
    a_hs_idle: assert property (!i_conv_active |=> !o_hs_ref_power) else $error("hs");
    a_hs_need: assert property (i_conv_active && h && !w |=> o_hs_ref_power)
        else $error("hs");
    a_ref_wr: assert property (w |=> o_precision_reference_enable == $past(i_sfr_wdata[0]))
        else $error("ref");
    a_gnd_sense: assert property (i_track_sensor && !i_conv_phase |=> g) else $error("gnd");
    a_gnd_hs: assert property (i_conv_phase && h && !w |=> g) else $error("gnd");
    a_sens_wr: assert property (w |=> o_thermal_sensor_enable == $past(i_sfr_wdata[2]))
        else $error("sens");
    a_rd_zero: assert property (i_sfr_rd |=> (o_sfr_rdata & 8'hC2) == 8'h00)
        else $error("rdata");
    cover property (w);
    cover property (h && i_conv_phase);
    cover property (i_track_sensor && !i_conv_phase);
endmodule

/* File: dv/arsc_conv_model.sv */
// Converter phase model: one register, phases change only on clock edges
`timescale 1ns/1ps
module arsc_conv_model (input logic i_clk, input logic [2:0] i_cmd, output logic [2:0] o_st);
    initial o_st = 3'h0;
    always @(posedge i_clk) o_st <= i_cmd;
endmodule

/* File: dv/testbench.sv */
// Bench for the reference control block
`timescale 1ns/1ps
module testbench;
    logic i_clk = 0, i_nrst = 0, i_sfr_wr = 0, i_sfr_rd = 0;
    wire i_track_sensor, i_conv_phase, i_conv_active;
    logic [3:0] i_sfr_page = 4'h0;
    logic [7:0] i_sfr_addr = 8'hD1, i_sfr_wdata = 8'h00, o_sfr_rdata;
    logic [2:0] cmd = 3'h0;
    wire [7:0] q;
    int n_errors = 0, tests_run = 0, cyc = 0;
    arsc_conv_model cm (.i_clk, .i_cmd(cmd), .o_st({i_track_sensor, i_conv_phase, i_conv_active}));
    arsc_ctrl uut (.*, .o_reference_source_select(q[7:6]),
        .o_ground_route(q[5:4]), .o_hs_ref_power(q[3]), .o_precision_reference_enable(q[2]),
        .o_ext_pin_connect(q[1]), .o_thermal_sensor_enable(q[0]));
    initial forever #12.5 i_clk = !i_clk;
    always @(posedge i_clk) if (++cyc == 400) begin n_errors++; final_report; end
    task final_report;
        $display("errors %0d checks %0d", n_errors, tests_run);
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task chk(string n, logic [7:0] e, logic [7:0] g);
        tests_run++;
        if (g !== e) begin n_errors++; $display("wrong value %s %h %h", n, e, g); end
    endtask
    // A read compares against d; strobes drop at the edge that takes them
    task acc(logic [7:0] a, logic w, logic [7:0] d);
        @(posedge i_clk) {i_sfr_addr, i_sfr_wr, i_sfr_rd, i_sfr_wdata} <= {a, w, !w, d};
        @(posedge i_clk) {i_sfr_wr, i_sfr_rd} <= 2'h0;
        @(negedge i_clk) if (!w) chk("rdata", d, o_sfr_rdata);
    endtask
    // Phase inputs pass the model register and the block register first
    task ctl(logic [2:0] c, logic [7:0] e);
        @(posedge i_clk) cmd <= c;
        repeat (3) @(negedge i_clk);
        chk("controls", e, q);
    endtask
    initial begin
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        acc(8'hD1, 0, 8'h18);
        acc(8'hD1, 1, 8'hFF);
        acc(8'hD1, 0, 8'h3D);
        acc(8'hD0, 0, 8'h00);
        @(posedge i_clk) i_sfr_page <= 4'h1;
        acc(8'hD1, 1, 8'h00);
        acc(8'hD1, 0, 8'h00);
        @(posedge i_clk) i_sfr_page <= 4'h0;
        acc(8'hD1, 0, 8'h3D);
        for (int s = 0; s < 4; s++) begin
            acc(8'hD1, 1, {3'h7, s[1:0], 3'h0});
            ctl(3'h3, {s[1:0], s == 3 ? 2'h2 : 2'h1, s == 3, 3'h0});
        end
        ctl(3'h5, 8'hE8);
        ctl(3'h0, 8'hD0);
        acc(8'hD1, 1, 8'h01);
        ctl(3'h0, 8'h06);
        acc(8'hD1, 1, 8'h04);
        ctl(3'h0, 8'h01);
        final_report;
    end
endmodule
bind arsc_ctrl arsc_chk chk_i (.*);
